// [pkg/lcs_pkg.sv]
// Constants, register map and types for the latching control switch bank
package lcs_pkg;
    localparam int SWITCH_COUNT = 5;
    localparam int SW_IDX_W     = 3;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;
    localparam int BE_W         = 4;
    localparam int STAMP_W      = 32;

    localparam logic [ADDR_W-1:0] ADDR_STATE      = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MIMIC_LVL  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_OPER_LVL   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LOCAL_CMD  = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE_CMD = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_SEL  = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_TIMESTAMP  = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_LAST_EVENT = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_LAST_STAMP = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_NAME_FIRST = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_NAME_LAST  = 8'hdc;

    typedef enum logic [1:0] {
        LEVEL_USER         = 2'b00,
        LEVEL_OPERATOR     = 2'b01,
        LEVEL_CONFIGURATOR = 2'b10,
        LEVEL_SUPER        = 2'b11
    } access_level_e;

    localparam access_level_e MIMIC_LVL_RESET = LEVEL_CONFIGURATOR;
    localparam access_level_e OPER_LVL_RESET  = LEVEL_USER;

    localparam int CMD_STATE_BIT     = 8;
    localparam int EVSEL_ON_BIT      = 0;
    localparam int EVSEL_OFF_BIT     = 1;
    localparam logic [1:0] EVSEL_RESET = 2'h3;
    localparam int STATUS_DENIED_BIT = 0;
    localparam int STATUS_BADIDX_BIT = 1;
    localparam int LAST_OFF_LSB      = 8;
    localparam logic SWITCH_RESET_STATE = 1'h0;

    localparam int NAME_CHARS        = 32;
    localparam int NAME_WORDS_PER_SW = NAME_CHARS / BE_W;
    localparam int NAME_WORDS        = SWITCH_COUNT * NAME_WORDS_PER_SW;
    localparam int NAME_IDX_W        = 6;
    localparam logic [NAME_IDX_W-1:0] NAME_BASE_IDX = 6'h10;
    localparam logic [DATA_W-1:0] NAME_WORD0      = 32'h74697753;
    localparam logic [DATA_W-1:0] NAME_WORD1_BASE = 32'h00006863;
    localparam logic [7:0]        NAME_DIGIT0     = 8'h31;
    localparam int                NAME_DIGIT_LSB  = 16;
endpackage : lcs_pkg

// [verilog/switch_cell.sv]
// One latching switch with change detection and change pulses
`timescale 1ns/1ps
module switch_cell
    import lcs_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic cmd_valid,
    input  wire logic cmd_state,
    output logic      state,
    output logic      turned_on,
    output logic      turned_off
);
    logic state_reg;
    logic state_next;
    logic on_reg;
    logic off_reg;
    logic change;

    assign change     = cmd_valid & (cmd_state != state_reg);
    assign state_next = change ? cmd_state : state_reg;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= SWITCH_RESET_STATE;
            on_reg    <= 1'b0;
            off_reg   <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            on_reg    <= change & cmd_state;
            off_reg   <= change & ~cmd_state;
        end
    end

    assign state      = state_reg;
    assign turned_on  = on_reg;
    assign turned_off = off_reg;
endmodule : switch_cell

// [verilog/name_store.sv]
// Name memory holding one 32-character name per switch
`timescale 1ns/1ps
module name_store
    import lcs_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  wr_en,
    input  wire logic [NAME_IDX_W-1:0] wr_index,
    input  wire logic [DATA_W-1:0]     wr_data,
    input  wire logic [BE_W-1:0]       wr_be,
    input  wire logic [NAME_IDX_W-1:0] rd_index,
    output logic      [DATA_W-1:0]     rd_data
);
    logic [DATA_W-1:0] mem [NAME_WORDS];

    function automatic logic [DATA_W-1:0] default_word(input int w);
        int sw;
        int pos;
        logic [7:0] digit;
        sw    = w / NAME_WORDS_PER_SW;
        pos   = w % NAME_WORDS_PER_SW;
        digit = NAME_DIGIT0 + 8'(sw);
        default_word = '0;
        if (pos == 0)
            default_word = NAME_WORD0;
        else if (pos == 1)
            default_word = NAME_WORD1_BASE
                         | (DATA_W'(digit) << NAME_DIGIT_LSB);
    endfunction : default_word

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int w = 0; w < NAME_WORDS; w++)
                mem[w] <= default_word(w);
        end
        else if (wr_en)
        begin
            for (int b = 0; b < BE_W; b++)
                if (wr_be[b])
                    mem[wr_index][b*8 +: 8] <= wr_data[b*8 +: 8];
        end
    end

    assign rd_data = mem[rd_index];
endmodule : name_store

// [verilog/latching_control_switch_bank.sv]
// Bank of latching control switches with Avalon-MM register access
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Each switch holds its last commanded state until told the opposite.
// - Switch commands come only from the local panel or the remote station.
// - No auxiliary input such as digital inputs or logic can move a switch.
// - Local commands need the operator level at or above the mimic level.
// - Five independent switches, each with its own state and events.
// - A change to ON raises that switch's ON event, to OFF its OFF event.
// - A selection decides whether ON, OFF or both events are stored.
// - Every recorded event carries a time stamp.
// - Each switch keeps a 32-character name defaulting to Switch plus its index plus one.
// - Switch outputs feed both direct output control and user logic.
module latching_control_switch_bank
    import lcs_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    input  wire logic [ADDR_W-1:0]       avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [DATA_W-1:0]       avs_writedata,
    input  wire logic [BE_W-1:0]         avs_byteenable,
    output logic      [DATA_W-1:0]       avs_readdata,
    output logic                         avs_waitrequest,
    output logic      [SWITCH_COUNT-1:0] switch_out,
    output logic      [SWITCH_COUNT-1:0] event_on,
    output logic      [SWITCH_COUNT-1:0] event_off,
    output logic      [STAMP_W-1:0]      event_stamp
);
    logic                    waitrequest_reg;
    logic [DATA_W-1:0]       readdata_reg;
    logic [DATA_W-1:0]       readdata_next;
    access_level_e           mimic_lvl_reg;
    access_level_e           oper_lvl_reg;
    logic [1:0]              evsel_reg;
    logic [1:0]              status_reg;
    logic [1:0]              status_next;
    logic [STAMP_W-1:0]      stamp_reg;
    logic [STAMP_W-1:0]      stamp_next;
    logic [SWITCH_COUNT-1:0] switch_reg;
    logic [SWITCH_COUNT-1:0] event_on_reg;
    logic [SWITCH_COUNT-1:0] event_off_reg;
    logic [STAMP_W-1:0]      event_stamp_reg;
    logic [SWITCH_COUNT-1:0] last_on_reg;
    logic [SWITCH_COUNT-1:0] last_off_reg;
    logic [STAMP_W-1:0]      last_stamp_reg;

    wire                     req_any;
    wire                     req_first;
    wire                     wr_go;
    wire                     be_low_full;
    wire                     sel_state;
    wire                     sel_mimic;
    wire                     sel_oper;
    wire                     sel_local;
    wire                     sel_remote;
    wire                     sel_evsel;
    wire                     sel_status;
    wire                     sel_stamp;
    wire                     sel_last_ev;
    wire                     sel_last_st;
    wire                     sel_name;
    wire [NAME_IDX_W-1:0]    name_index;
    wire [DATA_W-1:0]        name_rdata;
    wire [SW_IDX_W-1:0]      cmd_index;
    wire                     cmd_value;
    wire                     index_ok;
    wire                     level_ok;
    wire                     local_go;
    wire                     remote_go;
    wire [SWITCH_COUNT-1:0]  cell_state;
    wire [SWITCH_COUNT-1:0]  cell_on;
    wire [SWITCH_COUNT-1:0]  cell_off;
    wire [SWITCH_COUNT-1:0]  store_on;
    wire [SWITCH_COUNT-1:0]  store_off;
    wire                     store_any;
    wire                     any_change;

    // Bus handshake: one wait cycle, then the transfer completes
    assign req_any   = avs_read | avs_write;
    assign req_first = req_any & waitrequest_reg;
    assign wr_go     = avs_write & ~waitrequest_reg;
    assign be_low_full = avs_byteenable[0] & avs_byteenable[1];

    // Address decoding
    assign sel_state   = (avs_address == ADDR_STATE);
    assign sel_mimic   = (avs_address == ADDR_MIMIC_LVL);
    assign sel_oper    = (avs_address == ADDR_OPER_LVL);
    assign sel_local   = (avs_address == ADDR_LOCAL_CMD);
    assign sel_remote  = (avs_address == ADDR_REMOTE_CMD);
    assign sel_evsel   = (avs_address == ADDR_EVENT_SEL);
    assign sel_status  = (avs_address == ADDR_STATUS);
    assign sel_stamp   = (avs_address == ADDR_TIMESTAMP);
    assign sel_last_ev = (avs_address == ADDR_LAST_EVENT);
    assign sel_last_st = (avs_address == ADDR_LAST_STAMP);
    assign sel_name    = (avs_address >= ADDR_NAME_FIRST)
                       & (avs_address <= ADDR_NAME_LAST);
    assign name_index  = avs_address[ADDR_W-1:2] - NAME_BASE_IDX;

    // Command decoding; only the two command registers reach a switch
    assign cmd_index = avs_writedata[SW_IDX_W-1:0];
    assign cmd_value = avs_writedata[CMD_STATE_BIT];
    assign index_ok  = (cmd_index < SW_IDX_W'(SWITCH_COUNT));
    assign level_ok  = (oper_lvl_reg >= mimic_lvl_reg);
    assign local_go  = wr_go & sel_local & be_low_full & index_ok
                     & level_ok;
    assign remote_go = wr_go & sel_remote & be_low_full & index_ok;

    genvar gi;
    generate
        for (gi = 0; gi < SWITCH_COUNT; gi++)
        begin : g_switch
            wire hit;
            // Writes reach only the addressed switch; nothing else drives it
            assign hit = (local_go | remote_go)
                       & (cmd_index == SW_IDX_W'(gi));
            switch_cell u_cell (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .cmd_valid  (hit),
                .cmd_state  (cmd_value),
                .state      (cell_state[gi]),
                .turned_on  (cell_on[gi]),
                .turned_off (cell_off[gi])
            );
        end
    endgenerate

    // Event filtering for the main event buffer
    assign store_on   = cell_on & {SWITCH_COUNT{evsel_reg[EVSEL_ON_BIT]}};
    assign store_off  = cell_off & {SWITCH_COUNT{evsel_reg[EVSEL_OFF_BIT]}};
    assign store_any  = |(store_on | store_off);
    assign any_change = |(cell_on | cell_off);

    name_store u_names (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .wr_en    (wr_go & sel_name),
        .wr_index (name_index),
        .wr_data  (avs_writedata),
        .wr_be    (avs_byteenable),
        .rd_index (name_index),
        .rd_data  (name_rdata)
    );

    // Sticky refusal flags: a new refusal wins over a write-one clear
    always_comb
    begin
        status_next = status_reg;
        if (wr_go & sel_status & avs_byteenable[0])
            status_next = status_reg & ~avs_writedata[1:0];
        if (wr_go & sel_local & be_low_full & index_ok & ~level_ok)
            status_next[STATUS_DENIED_BIT] = 1'b1;
        if (wr_go & (sel_local | sel_remote) & be_low_full & ~index_ok)
            status_next[STATUS_BADIDX_BIT] = 1'b1;
    end

    // Free-running time base, loadable by software
    always_comb
    begin
        stamp_next = stamp_reg + STAMP_W'(1);
        if (wr_go & sel_stamp)
        begin
            for (int b = 0; b < BE_W; b++)
                if (avs_byteenable[b])
                    stamp_next[b*8 +: 8] = avs_writedata[b*8 +: 8];
        end
    end

    // Read data selection
    always_comb
    begin
        readdata_next = '0;
        if (sel_state)
            readdata_next[SWITCH_COUNT-1:0] = cell_state;
        else if (sel_mimic)
            readdata_next[1:0] = mimic_lvl_reg;
        else if (sel_oper)
            readdata_next[1:0] = oper_lvl_reg;
        else if (sel_evsel)
            readdata_next[1:0] = evsel_reg;
        else if (sel_status)
            readdata_next[1:0] = status_reg;
        else if (sel_stamp)
            readdata_next = stamp_reg;
        else if (sel_last_ev)
        begin
            readdata_next[SWITCH_COUNT-1:0] = last_on_reg;
            readdata_next[LAST_OFF_LSB +: SWITCH_COUNT] = last_off_reg;
        end
        else if (sel_last_st)
            readdata_next = last_stamp_reg;
        else if (sel_name)
            readdata_next = name_rdata;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            waitrequest_reg <= 1'b1;
            readdata_reg    <= '0;
        end
        else
        begin
            waitrequest_reg <= ~req_first;
            if (req_first)
                readdata_reg <= readdata_next;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mimic_lvl_reg <= MIMIC_LVL_RESET;
            oper_lvl_reg  <= OPER_LVL_RESET;
            evsel_reg     <= EVSEL_RESET;
        end
        else if (wr_go & avs_byteenable[0])
        begin
            if (sel_mimic)
                mimic_lvl_reg <= access_level_e'(avs_writedata[1:0]);
            if (sel_oper)
                oper_lvl_reg <= access_level_e'(avs_writedata[1:0]);
            if (sel_evsel)
                evsel_reg <= avs_writedata[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            status_reg <= '0;
            stamp_reg  <= '0;
        end
        else
        begin
            status_reg <= status_next;
            stamp_reg  <= stamp_next;
        end
    end

    // Output stage and record of the latest stored events
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            switch_reg      <= '0;
            event_on_reg    <= '0;
            event_off_reg   <= '0;
            event_stamp_reg <= '0;
            last_on_reg     <= '0;
            last_off_reg    <= '0;
            last_stamp_reg  <= '0;
        end
        else
        begin
            switch_reg    <= cell_state;
            event_on_reg  <= store_on;
            event_off_reg <= store_off;
            if (any_change)
                event_stamp_reg <= stamp_reg;
            if (store_any)
            begin
                last_on_reg    <= store_on;
                last_off_reg   <= store_off;
                last_stamp_reg <= stamp_reg;
            end
        end
    end

    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign switch_out      = switch_reg;
    assign event_on        = event_on_reg;
    assign event_off       = event_off_reg;
    assign event_stamp     = event_stamp_reg;
endmodule : latching_control_switch_bank

// [test/lcs_properties.sv]
// Concurrent checks on the ports of the switch bank
`timescale 1ns/1ps
module lcs_checker
    import lcs_pkg::*;
(
    input wire logic                    clk_sys,
    input wire logic                    rst,
    input wire logic [ADDR_W-1:0]       avs_address,
    input wire logic                    avs_read,
    input wire logic                    avs_write,
    input wire logic [DATA_W-1:0]       avs_writedata,
    input wire logic [BE_W-1:0]         avs_byteenable,
    input wire logic [DATA_W-1:0]       avs_readdata,
    input wire logic                    avs_waitrequest,
    input wire logic [SWITCH_COUNT-1:0] switch_out,
    input wire logic [SWITCH_COUNT-1:0] event_on,
    input wire logic [SWITCH_COUNT-1:0] event_off,
    input wire logic [STAMP_W-1:0]      event_stamp
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    wire cmd_addr  = avs_address == ADDR_LOCAL_CMD
                  || avs_address == ADDR_REMOTE_CMD;
    wire cmd_taken = avs_write && !avs_waitrequest && cmd_addr;
    wire any_event = (event_on | event_off) != '0;

    sequence req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence one_low;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_wait_answer: assert property (req_seen |=> one_low)
        else $error("waitrequest not low for one cycle");
    a_idle_wait: assert property (!$past(avs_read || avs_write)
        |-> avs_waitrequest) else $error("waitrequest low when idle");
    a_state_cause: assert property ($changed(switch_out)
        |-> $past(cmd_taken, 2)) else $error("switch moved without command");
    a_single_change: assert property ($changed(switch_out)
        |-> $onehot(switch_out ^ $past(switch_out)))
        else $error("more than one switch moved");
    a_on_event: assert property (event_on != '0 |->
        ((event_on & ~switch_out) | (event_on & $past(switch_out))) == '0)
        else $error("on event without rise");
    a_off_event: assert property (event_off != '0 |->
        ((event_off & switch_out) | (event_off & ~$past(switch_out))) == '0)
        else $error("off event without fall");
    a_event_pulse: assert property (any_event |=> !any_event)
        else $error("event longer than one cycle");
    a_no_change: assert property (!$changed(switch_out) |-> !any_event)
        else $error("event without state change");
    a_stamp_hold: assert property ($changed(event_stamp)
        |-> $changed(switch_out)) else $error("stamp moved alone");
endmodule : lcs_checker

bind latching_control_switch_bank lcs_checker u_chk (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .switch_out(switch_out), .event_on(event_on),
    .event_off(event_off), .event_stamp(event_stamp)
);

// [test/panel_station.sv]
// Bus master model of the local panel and the remote station
`timescale 1ns/1ps
module panel_station
    import lcs_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              avs_waitrequest,
    input  wire logic [DATA_W-1:0] avs_readdata,
    output logic      [ADDR_W-1:0] avs_address,
    output logic                   avs_read,
    output logic                   avs_write,
    output logic      [DATA_W-1:0] avs_writedata,
    output logic      [BE_W-1:0]   avs_byteenable
);
    initial
    begin
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = '0;
    end

    // Only path to the switches; no auxiliary source exists
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [BE_W-1:0] bev,
        input int gap, output logic [DATA_W-1:0] rd, output logic ok);
        int n;
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= d;
        avs_byteenable <= bev;
        n = 0;
        ok = 1'b0;
        rd = '0;
        while (!ok && n < 64)
        begin
            @(posedge clk_sys);
            n++;
            if (avs_waitrequest === 1'b0)
            begin
                ok = 1'b1;
                rd = avs_readdata;
            end
        end
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask : xfer
endmodule : panel_station

// [test/latching_control_switch_bank_tb.sv]
// Self-checking bench for the latching control switch bank
`timescale 1ns/1ps
module latching_control_switch_bank_tb;
    import lcs_pkg::*;
    logic                    clk_sys;
    logic                    rst;
    logic [ADDR_W-1:0]       address;
    logic                    rd_en;
    logic                    wr_en;
    logic [DATA_W-1:0]       wdata;
    logic [BE_W-1:0]         be;
    logic [DATA_W-1:0]       rdata;
    logic                    wait_req;
    logic [SWITCH_COUNT-1:0] switch_out;
    logic [SWITCH_COUNT-1:0] event_on;
    logic [SWITCH_COUNT-1:0] event_off;
    logic [STAMP_W-1:0]      event_stamp;
    logic [SWITCH_COUNT-1:0] model;
    logic [15:0]             lfsr;
    logic [1:0]              evsel;
    logic [DATA_W-1:0]       rd;
    logic                    ok;
    int                      fail_count;
    int                      n_checks;
    int                      cyc = 0;
    int                      t0;
    logic [STAMP_W-1:0]      stamp_base;
    logic [STAMP_W-1:0]      last_st;
    logic [BE_W-1:0]         be_sel;

    always @(posedge clk_sys) cyc <= cyc + 1;

    latching_control_switch_bank u_dut (.clk_sys(clk_sys), .rst(rst),
        .avs_address(address), .avs_read(rd_en), .avs_write(wr_en),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .switch_out(switch_out),
        .event_on(event_on), .event_off(event_off),
        .event_stamp(event_stamp));
    panel_station u_panel (.clk_sys(clk_sys), .avs_waitrequest(wait_req),
        .avs_readdata(rdata), .avs_address(address), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    function automatic logic [DATA_W-1:0] name_word1(input int i);
        return NAME_WORD1_BASE
            | (DATA_W'(NAME_DIGIT0 + 8'(i)) << NAME_DIGIT_LSB);
    endfunction : name_word1

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        u_panel.xfer(wr, a, d, be_sel, int'(lfsr[1:0]), rd, ok);
        lfsr = lfsr_next(lfsr);
        if (!ok)
        begin
            fail_count++;
            $display("MISMATCH t=%0t bus timeout", $time);
            summarize();
        end
    endtask : bus

    task automatic rdchk(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] exp);
        bus(1'b0, a, '0);
        check(rd, exp, "register read");
    endtask : rdchk

    task automatic cmd(input logic [ADDR_W-1:0] a, input logic [2:0] idx,
        input logic tgt, input logic allow);
        logic [SWITCH_COUNT-1:0] m;
        logic [SWITCH_COUNT-1:0] s;
        logic [STAMP_W-1:0]      st;
        logic [DATA_W-1:0]       le;
        m = '0;
        if (idx < 3'(SWITCH_COUNT) && allow && model[idx] !== tgt)
            m[idx] = 1'b1;
        s = (tgt ? evsel[0] : evsel[1]) ? m : '0;
        le = tgt ? {27'h0, s} : {19'h0, s, 8'h0};
        bus(1'b1, a, {23'h0, tgt, 5'h0, idx});
        st = stamp_base + STAMP_W'(cyc - t0);
        if (m != '0)
            last_st = st;
        @(posedge clk_sys);
        #1;
        model = model ^ m;
        check(switch_out, model, "state");
        check(event_on, tgt ? s : '0, "on event");
        check(event_off, tgt ? '0 : s, "off event");
        check(event_stamp, last_st, "event stamp");
        if (s != '0)
        begin
            rdchk(ADDR_LAST_STAMP, st);
            rdchk(ADDR_LAST_EVENT, le);
        end
    endtask : cmd

    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        rst = 1'b1;
        fail_count = 0;
        n_checks = 0;
        lfsr = 16'h003d;
        model = '0;
        last_st = '0;
        be_sel = 4'hf;
        evsel = EVSEL_RESET;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check(switch_out, '0, "reset state");
        check(event_on | event_off, '0, "reset events");
        rdchk(ADDR_STATE, '0);
        rdchk(ADDR_MIMIC_LVL, 32'h2);
        rdchk(ADDR_OPER_LVL, 32'h0);
        rdchk(ADDR_STATUS, 32'h0);
        rdchk(ADDR_EVENT_SEL, 32'h3);
        for (int i = 0; i < SWITCH_COUNT; i++)
        begin
            rdchk(ADDR_NAME_FIRST + 8'(i * 32), NAME_WORD0);
            rdchk(ADDR_NAME_FIRST + 8'(i * 32 + 4), name_word1(i));
        end
        bus(1'b1, ADDR_NAME_FIRST + 8'h1c, 32'h61626364);
        rdchk(ADDR_NAME_FIRST + 8'h1c, 32'h61626364);
        bus(1'b1, 8'h30, 32'hffffffff);
        rdchk(8'h30, '0);
        stamp_base = {16'hffff, lfsr};
        bus(1'b1, ADDR_TIMESTAMP, stamp_base);
        t0 = cyc;
        bus(1'b0, ADDR_TIMESTAMP, '0);
        check(rd, stamp_base + STAMP_W'(cyc - t0 - 2), "time base");
        $display("test reset_values done");
        for (int mv = 0; mv < 4; mv++)
            for (int ov = 0; ov < 4; ov++)
            begin
                bus(1'b1, ADDR_MIMIC_LVL, 32'(mv));
                bus(1'b1, ADDR_OPER_LVL, 32'(ov));
                cmd(ADDR_LOCAL_CMD, 3'd0, ~model[0], ov >= mv);
                rdchk(ADDR_STATUS, 32'(ov < mv));
                bus(1'b1, ADDR_STATUS, 32'h3);
            end
        $display("test access_levels done");
        for (int k = 0; k < 60; k++)
        begin
            if (k % 8 == 0)
            begin
                evsel = lfsr[3:2];
                bus(1'b1, ADDR_EVENT_SEL, {30'h0, evsel});
            end
            cmd(lfsr[4] ? ADDR_LOCAL_CMD : ADDR_REMOTE_CMD,
                3'(lfsr[15:8] % 8'd5), lfsr[0], 1'b1);
            rdchk(ADDR_STATE, {27'h0, model});
        end
        $display("test random_commands done");
        for (int j = 5; j < 8; j++)
        begin
            cmd(ADDR_REMOTE_CMD, 3'(j), 1'b1, 1'b0);
            rdchk(ADDR_STATUS, 32'h2);
            bus(1'b1, ADDR_STATUS, 32'h3);
        end
        be_sel = 4'h1;
        cmd(ADDR_REMOTE_CMD, 3'd1, ~model[1], 1'b0);
        be_sel = 4'hf;
        rdchk(ADDR_STATUS, 32'h0);
        $display("test bad_index done");
        summarize();
    end
endmodule : latching_control_switch_bank_tb
